// ### rtl/mie_core.sv
/*
 * Execute stage for a subset of an 8-bit controller instruction set: extended skips,
 * table reads, misc byte operations, add/and/call/clear/complement/decimal adjust/decrement
 * and halt with watchdog flag handling.
 * Assumes a decoder presents i_op with i_op_valid and waits for o_ready; data memory answers
 * reads combinationally on i_mem_rdata for the address the decoder drives; program memory
 * answers o_rom_addr on i_rom_data while o_rom_re stands.
 */
`timescale 1ns/10ps
`default_nettype none
module mie_core #(
	parameter int PC_W = 13
) (
	input  wire logic            i_clk,
	input  wire logic            i_rst_n,
	input  wire logic            i_ce,
	input  wire logic            i_op_valid,
	input  wire mie_pkg::mie_op_t i_op,
	input  wire logic      [7:0] i_imm,
	input  wire logic      [2:0] i_bit,
	input  wire logic            i_pcl_dest,
	input  wire logic [PC_W-1:0] i_pc,
	input  wire logic [PC_W-1:0] i_target,
	input  wire logic      [7:0] i_mem_rdata,
	input  wire logic     [15:0] i_rom_data,
	input  wire logic      [7:0] i_tbl_page,
	input  wire logic            i_wake,
	output logic                 o_ready,
	output logic                 o_skip,
	output logic                 o_mem_we,
	output logic           [7:0] o_mem_wdata,
	output logic [PC_W-1:0]      o_rom_addr,
	output logic                 o_rom_re,
	output logic                 o_push,
	output logic [PC_W-1:0]      o_push_addr,
	output logic                 o_pc_load,
	output logic [PC_W-1:0]      o_pc_target,
	output logic                 o_wdt_clear,
	output logic                 o_clk_gate,
	output logic           [7:0] o_acc,
	output logic           [4:0] o_flags,
	output logic           [7:0] o_table_pointer_reg,
	output logic           [7:0] o_table_high_byte_reg,
	output logic                 o_timeout_flag,
	output logic                 o_power_down_flag
);
	if (PC_W < 9 || PC_W > 16) begin : g_pc_w_check
		$error("PC_W must lie in 9..16");
	end

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_BUSY = 4'b0010,
		ST_ROM  = 4'b0100,
		ST_HALT = 4'b1000
	} mie_st_t;

	typedef struct packed {
		mie_st_t          st;
		logic [1:0]       cnt;
		logic             ready;
		logic             skip;
		logic             we;
		logic [7:0]       wdata;
		logic [PC_W-1:0]  rom_addr;
		logic             rom_re;
		logic             push;
		logic [PC_W-1:0]  push_addr;
		logic             pc_load;
		logic [PC_W-1:0]  pc_target;
		logic             wdt_clear;
		logic             gate;
		logic [7:0]       acc;
		logic [4:0]       flags;
		logic [7:0]       table_pointer_reg;
		logic [7:0]       table_high_byte_reg;
		logic             to;
		logic             power_down_flag;
	} mie_state_t;

	mie_state_t s_q;
	mie_state_t s_d;

	logic [7:0] alu_a;
	logic [7:0] alu_b;
	logic       alu_cin;
	logic [7:0] alu_sum;
	logic       alu_c;
	logic       alu_ac;
	logic       alu_ov;
	logic [7:0] alu_daa;
	logic       alu_daa_c;

	function automatic logic [PC_W-1:0] rom_addr_of(input logic last, input logic [7:0] page,
			input logic [7:0] ptr);
		logic [PC_W-1:0] a;
		a = '0;
		a[7:0] = ptr;
		a[PC_W-1:8] = last ? '1 : page[PC_W-9:0];
		return a;
	endfunction

	function automatic logic [1:0] skip_cycles(input logic skip);
		return skip ? mie_pkg::CYC_THREE : mie_pkg::CYC_TWO;
	endfunction

	mie_alu u_alu (
		.i_a     (alu_a),
		.i_b     (alu_b),
		.i_cin   (alu_cin),
		.i_ac    (s_q.flags[mie_pkg::F_AC]),
		.o_sum   (alu_sum),
		.o_c     (alu_c),
		.o_ac    (alu_ac),
		.o_ov    (alu_ov),
		.o_daa   (alu_daa),
		.o_daa_c (alu_daa_c)
	);

	always_comb begin
		logic [7:0] res;
		logic [7:0] ptr;
		logic       last;
		res      = mie_pkg::BYTE_ZERO;
		ptr      = s_q.table_pointer_reg;
		last     = 1'b0;
		s_d      = s_q;
		s_d.skip = 1'b0;
		s_d.we   = 1'b0;
		s_d.push = 1'b0;
		s_d.pc_load   = 1'b0;
		s_d.wdt_clear = 1'b0;
		s_d.rom_re    = 1'b0;
		alu_a    = s_q.acc;
		alu_b    = i_mem_rdata;
		alu_cin  = 1'b0;
		unique case (i_op)
			mie_pkg::OP_ADD_WITH_CARRY, mie_pkg::OP_ADD_WITH_CARRY_TO_MEM:
				alu_cin = s_q.flags[mie_pkg::F_C];
			mie_pkg::OP_ADD_IMM:
				alu_b = i_imm;
			mie_pkg::OP_EXT_INC_SKIP_ZERO, mie_pkg::OP_EXT_INC_SKIP_ZERO_TO_ACC: begin
				alu_a = i_mem_rdata;
				alu_b = 8'h01;
			end
			mie_pkg::OP_EXT_DEC_SKIP_ZERO, mie_pkg::OP_EXT_DEC_SKIP_ZERO_TO_ACC,
			mie_pkg::OP_DECREMENT_BYTE, mie_pkg::OP_DECREMENT_TO_ACC: begin
				alu_a = i_mem_rdata;
				alu_b = mie_pkg::BYTE_ONES;
			end
			mie_pkg::OP_DECIMAL_ADJUST:
				alu_cin = s_q.flags[mie_pkg::F_C];
			default: begin
			end
		endcase

		if (s_q.st == ST_IDLE && i_op_valid) begin
			s_d.ready = 1'b0;
			s_d.st    = ST_BUSY;
			s_d.cnt   = mie_pkg::CYC_ONE;
			unique case (i_op)
				mie_pkg::OP_EXT_SKIP_IF_ZERO:
					s_d.skip = (i_mem_rdata == mie_pkg::BYTE_ZERO);
				mie_pkg::OP_EXT_SKIP_IF_NONZERO:
					s_d.skip = (i_mem_rdata != mie_pkg::BYTE_ZERO);
				mie_pkg::OP_EXT_SKIP_BIT_ZERO:
					s_d.skip = !i_mem_rdata[i_bit];
				mie_pkg::OP_EXT_SKIP_BIT_NONZERO:
					s_d.skip = i_mem_rdata[i_bit];
				mie_pkg::OP_EXT_SKIP_ZERO_MOVE_TO_ACC: begin
					s_d.acc  = i_mem_rdata;
					s_d.skip = (i_mem_rdata == mie_pkg::BYTE_ZERO);
				end
				mie_pkg::OP_EXT_INC_SKIP_ZERO, mie_pkg::OP_EXT_DEC_SKIP_ZERO: begin
					s_d.we    = 1'b1;
					s_d.wdata = alu_sum;
					s_d.skip  = (alu_sum == mie_pkg::BYTE_ZERO);
				end
				mie_pkg::OP_EXT_INC_SKIP_ZERO_TO_ACC, mie_pkg::OP_EXT_DEC_SKIP_ZERO_TO_ACC: begin
					s_d.acc  = alu_sum;
					s_d.skip = (alu_sum == mie_pkg::BYTE_ZERO);
				end
				mie_pkg::OP_EXT_TABLE_READ_PAGE, mie_pkg::OP_EXT_TABLE_READ_LAST_PAGE,
				mie_pkg::OP_EXT_PREINC_TABLE_READ_PAGE, mie_pkg::OP_EXT_PREINC_TABLE_READ_LAST: begin
					if (i_op == mie_pkg::OP_EXT_PREINC_TABLE_READ_PAGE ||
							i_op == mie_pkg::OP_EXT_PREINC_TABLE_READ_LAST) begin
						ptr = s_q.table_pointer_reg + 8'h01;
					end
					last = (i_op == mie_pkg::OP_EXT_TABLE_READ_LAST_PAGE ||
						i_op == mie_pkg::OP_EXT_PREINC_TABLE_READ_LAST);
					s_d.table_pointer_reg     = ptr;
					s_d.rom_addr = rom_addr_of(last, i_tbl_page, ptr);
					s_d.rom_re   = 1'b1;
					s_d.st       = ST_ROM;
				end
				mie_pkg::OP_EXT_CLEAR_BYTE, mie_pkg::OP_CLEAR_BYTE: begin
					s_d.we    = 1'b1;
					s_d.wdata = mie_pkg::BYTE_ZERO;
				end
				mie_pkg::OP_EXT_SET_BYTE: begin
					s_d.we    = 1'b1;
					s_d.wdata = mie_pkg::BYTE_ONES;
				end
				mie_pkg::OP_EXT_NIBBLE_SWAP: begin
					s_d.we    = 1'b1;
					s_d.wdata = {i_mem_rdata[3:0], i_mem_rdata[7:4]};
				end
				mie_pkg::OP_EXT_NIBBLE_SWAP_TO_ACC:
					s_d.acc = {i_mem_rdata[3:0], i_mem_rdata[7:4]};
				mie_pkg::OP_ADD_WITH_CARRY, mie_pkg::OP_ADD, mie_pkg::OP_ADD_IMM,
				mie_pkg::OP_ADD_WITH_CARRY_TO_MEM, mie_pkg::OP_ADD_TO_MEM: begin
					s_d.flags[mie_pkg::F_C]  = alu_c;
					s_d.flags[mie_pkg::F_SC] = alu_c;
					s_d.flags[mie_pkg::F_AC] = alu_ac;
					s_d.flags[mie_pkg::F_OV] = alu_ov;
					s_d.flags[mie_pkg::F_Z]  = (alu_sum == mie_pkg::BYTE_ZERO);
					if (i_op == mie_pkg::OP_ADD_WITH_CARRY_TO_MEM ||
							i_op == mie_pkg::OP_ADD_TO_MEM) begin
						s_d.we    = 1'b1;
						s_d.wdata = alu_sum;
					end else begin
						s_d.acc = alu_sum;
					end
				end
				mie_pkg::OP_AND, mie_pkg::OP_AND_IMM, mie_pkg::OP_AND_TO_MEM: begin
					res = s_q.acc & ((i_op == mie_pkg::OP_AND_IMM) ? i_imm : i_mem_rdata);
					s_d.flags[mie_pkg::F_Z] = (res == mie_pkg::BYTE_ZERO);
					if (i_op == mie_pkg::OP_AND_TO_MEM) begin
						s_d.we    = 1'b1;
						s_d.wdata = res;
					end else begin
						s_d.acc = res;
					end
				end
				mie_pkg::OP_CALL: begin
					s_d.push      = 1'b1;
					s_d.push_addr = i_pc + {{(PC_W-1){1'b0}}, 1'b1};
					s_d.pc_load   = 1'b1;
					s_d.pc_target = i_target;
				end
				mie_pkg::OP_CLEAR_BIT: begin
					res         = i_mem_rdata;
					res[i_bit]  = 1'b0;
					s_d.we      = 1'b1;
					s_d.wdata   = res;
				end
				mie_pkg::OP_CLEAR_WATCHDOG: begin
					s_d.wdt_clear = 1'b1;
					s_d.to        = 1'b0;
					s_d.power_down_flag       = 1'b0;
				end
				mie_pkg::OP_COMPLEMENT_BYTE, mie_pkg::OP_COMPLEMENT_TO_ACC: begin
					res = ~i_mem_rdata;
					s_d.flags[mie_pkg::F_Z] = (res == mie_pkg::BYTE_ZERO);
					if (i_op == mie_pkg::OP_COMPLEMENT_BYTE) begin
						s_d.we    = 1'b1;
						s_d.wdata = res;
					end else begin
						s_d.acc = res;
					end
				end
				mie_pkg::OP_DECIMAL_ADJUST: begin
					s_d.we    = 1'b1;
					s_d.wdata = alu_daa;
					s_d.flags[mie_pkg::F_C] = alu_daa_c;
				end
				mie_pkg::OP_DECREMENT_BYTE, mie_pkg::OP_DECREMENT_TO_ACC: begin
					s_d.flags[mie_pkg::F_Z] = (alu_sum == mie_pkg::BYTE_ZERO);
					if (i_op == mie_pkg::OP_DECREMENT_BYTE) begin
						s_d.we    = 1'b1;
						s_d.wdata = alu_sum;
					end else begin
						s_d.acc = alu_sum;
					end
				end
				mie_pkg::OP_HALT: begin
					s_d.wdt_clear = 1'b1;
					s_d.power_down_flag       = 1'b1;
					s_d.to        = 1'b0;
					s_d.gate      = 1'b1;
					s_d.st        = ST_HALT;
				end
				default: begin
					s_d.cnt = mie_pkg::CYC_ONE;
				end
			endcase
			// total cycles: skips 2/3, PROGRAM_COUNTER_LOW destination 3, table reads 3, other extended ops and call 2
			if (s_d.skip) begin
				s_d.cnt = skip_cycles(1'b1) - mie_pkg::CYC_ONE;
			end else if (i_pcl_dest) begin
				s_d.cnt = mie_pkg::CYC_THREE - mie_pkg::CYC_ONE;
			end else if (i_op != mie_pkg::OP_NOP && i_op != mie_pkg::OP_HALT) begin
				s_d.cnt = skip_cycles(1'b0) - mie_pkg::CYC_ONE;
			end else begin
				s_d.cnt = mie_pkg::CYC_ONE;
			end
		end else if (s_q.st == ST_ROM) begin
			s_d.table_high_byte_reg  = i_rom_data[15:8];
			s_d.we    = 1'b1;
			s_d.wdata = i_rom_data[7:0];
			s_d.cnt   = mie_pkg::CYC_ONE;
			s_d.st    = ST_BUSY;
		end else if (s_q.st == ST_BUSY) begin
			if (s_q.cnt == mie_pkg::CYC_ONE) begin
				s_d.ready = 1'b1;
				s_d.st    = ST_IDLE;
			end
			s_d.cnt = s_q.cnt - mie_pkg::CYC_ONE;
			s_d.skip = s_q.skip;
		end else if (s_q.st == ST_HALT) begin
			if (i_wake) begin
				s_d.gate  = 1'b0;
				s_d.ready = 1'b1;
				s_d.st    = ST_IDLE;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s_q           <= '0;
			s_q.st        <= ST_IDLE;
			s_q.ready     <= 1'b1;
			s_q.acc       <= mie_pkg::RST_ACC;
			s_q.flags     <= mie_pkg::RST_FLAGS;
			s_q.table_pointer_reg      <= mie_pkg::RST_TABLE_POINTER_REG;
			s_q.table_high_byte_reg      <= mie_pkg::RST_TABLE_HIGH_BYTE_REG;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	assign o_ready           = s_q.ready;
	assign o_skip            = s_q.skip;
	assign o_mem_we          = s_q.we;
	assign o_mem_wdata       = s_q.wdata;
	assign o_rom_addr        = s_q.rom_addr;
	assign o_rom_re          = s_q.rom_re;
	assign o_push            = s_q.push;
	assign o_push_addr       = s_q.push_addr;
	assign o_pc_load         = s_q.pc_load;
	assign o_pc_target       = s_q.pc_target;
	assign o_wdt_clear       = s_q.wdt_clear;
	assign o_clk_gate        = s_q.gate;
	assign o_acc             = s_q.acc;
	assign o_flags           = s_q.flags;
	assign o_table_pointer_reg            = s_q.table_pointer_reg;
	assign o_table_high_byte_reg            = s_q.table_high_byte_reg;
	assign o_timeout_flag    = s_q.to;
	assign o_power_down_flag = s_q.power_down_flag;

	halt_flags_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && s_q.st == ST_IDLE && i_op_valid && i_op == mie_pkg::OP_HALT) |=>
		(o_power_down_flag && !o_timeout_flag && o_wdt_clear && o_clk_gate))
		else $error("halt did not set power down state");
	clrwdt_flags_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && s_q.st == ST_IDLE && i_op_valid && i_op == mie_pkg::OP_CLEAR_WATCHDOG) |=>
		(!o_power_down_flag && !o_timeout_flag && o_wdt_clear))
		else $error("clear watchdog left flags set");
	call_push_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && s_q.st == ST_IDLE && i_op_valid && i_op == mie_pkg::OP_CALL && !i_pcl_dest) |=>
		(o_push && o_pc_load && !o_ready && $stable(o_flags)) ##1 o_ready)
		else $error("call push or length wrong");
	skip_three_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && s_q.st == ST_IDLE && i_op_valid && i_op == mie_pkg::OP_EXT_SKIP_IF_ZERO &&
		i_mem_rdata == 8'h00) |=> (!o_ready && o_skip) ##1 (!o_ready && o_skip) ##1 o_ready)
		else $error("skip length wrong");
	table_rom_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && s_q.st == ST_ROM) |=> (o_mem_we && o_table_high_byte_reg == $past(i_rom_data[15:8])))
		else $error("table read did not load high byte");
	and_flags_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && s_q.st == ST_IDLE && i_op_valid && i_op == mie_pkg::OP_AND) |=>
		(o_flags[mie_pkg::F_C] == $past(o_flags[mie_pkg::F_C]) &&
		o_flags[mie_pkg::F_Z] == (o_acc == 8'h00)))
		else $error("and changed flags wrongly");
	halt_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(s_q.st == ST_HALT && !i_wake) |=> ($stable(o_acc) && o_clk_gate && !o_mem_we))
		else $error("state changed during power down");
	zero_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && s_q.st == ST_IDLE && i_op_valid && i_op == mie_pkg::OP_DECREMENT_TO_ACC) |=>
		(o_flags[mie_pkg::F_Z] == (o_acc == 8'h00)))
		else $error("zero flag mismatch");
endmodule
`default_nettype wire

// ### rtl/mie_pkg.sv
/*
 * Package for the instruction execute subset: operation codes, flag positions, cycle counts
 * and reset values.
 * Assumes a single 100 MHz clock domain and an external decoder that hands over one operation
 * at a time.
 */
package mie_pkg;

	localparam int DW = 8;

	// operation codes presented on the operation port
	typedef enum logic [5:0] {
		OP_NOP                        = 6'h00,
		OP_EXT_SKIP_IF_ZERO           = 6'h01,
		OP_EXT_SKIP_ZERO_MOVE_TO_ACC  = 6'h02,
		OP_EXT_SKIP_IF_NONZERO        = 6'h03,
		OP_EXT_SKIP_BIT_ZERO          = 6'h04,
		OP_EXT_SKIP_BIT_NONZERO       = 6'h05,
		OP_EXT_INC_SKIP_ZERO          = 6'h06,
		OP_EXT_DEC_SKIP_ZERO          = 6'h07,
		OP_EXT_INC_SKIP_ZERO_TO_ACC   = 6'h08,
		OP_EXT_DEC_SKIP_ZERO_TO_ACC   = 6'h09,
		OP_EXT_TABLE_READ_PAGE        = 6'h0A,
		OP_EXT_TABLE_READ_LAST_PAGE   = 6'h0B,
		OP_EXT_PREINC_TABLE_READ_PAGE = 6'h0C,
		OP_EXT_PREINC_TABLE_READ_LAST = 6'h0D,
		OP_EXT_CLEAR_BYTE             = 6'h0E,
		OP_EXT_SET_BYTE               = 6'h0F,
		OP_EXT_NIBBLE_SWAP            = 6'h10,
		OP_EXT_NIBBLE_SWAP_TO_ACC     = 6'h11,
		OP_ADD_WITH_CARRY             = 6'h12,
		OP_ADD_WITH_CARRY_TO_MEM      = 6'h13,
		OP_ADD                        = 6'h14,
		OP_ADD_IMM                    = 6'h15,
		OP_ADD_TO_MEM                 = 6'h16,
		OP_AND                        = 6'h17,
		OP_AND_IMM                    = 6'h18,
		OP_AND_TO_MEM                 = 6'h19,
		OP_CALL                       = 6'h1A,
		OP_CLEAR_BYTE                 = 6'h1B,
		OP_CLEAR_BIT                  = 6'h1C,
		OP_CLEAR_WATCHDOG             = 6'h1D,
		OP_COMPLEMENT_BYTE            = 6'h1E,
		OP_COMPLEMENT_TO_ACC          = 6'h1F,
		OP_DECIMAL_ADJUST             = 6'h20,
		OP_DECREMENT_BYTE             = 6'h21,
		OP_DECREMENT_TO_ACC           = 6'h22,
		OP_HALT                       = 6'h23
	} mie_op_t;

	// flag register bit positions
	localparam int F_C  = 0;
	localparam int F_AC = 1;
	localparam int F_Z  = 2;
	localparam int F_OV = 3;
	localparam int F_SC = 4;

	// cycle counts
	localparam logic [1:0] CYC_ONE   = 2'h1;
	localparam logic [1:0] CYC_TWO   = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;

	// decimal adjust constants
	localparam logic [7:0] DAA_LO  = 8'h06;
	localparam logic [7:0] DAA_HI  = 8'h60;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hFF;

	// reset values
	localparam logic [7:0] RST_ACC   = 8'h00;
	localparam logic [4:0] RST_FLAGS = 5'h00;
	localparam logic [7:0] RST_TABLE_POINTER_REG  = 8'h00;
	localparam logic [7:0] RST_TABLE_HIGH_BYTE_REG  = 8'h00;

endpackage

// ### rtl/mie_alu.sv
/*
 * Combinational arithmetic unit: add with carry, increment/decrement, decimal adjust.
 * Assumes operands are stable within the cycle; no state.
 */
`timescale 1ns/10ps
`default_nettype none
module mie_alu (
	input  wire logic [7:0] i_a,
	input  wire logic [7:0] i_b,
	input  wire logic       i_cin,
	input  wire logic       i_ac,
	output logic      [7:0] o_sum,
	output logic            o_c,
	output logic            o_ac,
	output logic            o_ov,
	output logic      [7:0] o_daa,
	output logic            o_daa_c
);
	logic [4:0] lo;
	logic [8:0] full;
	logic [7:0] adj;
	logic [8:0] daa_full;

	always_comb begin
		lo       = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
		full     = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
		o_sum    = full[7:0];
		o_c      = full[8];
		o_ac     = lo[4];
		o_ov     = (i_a[7] == i_b[7]) && (full[7] != i_a[7]);
		adj      = mie_pkg::BYTE_ZERO;
		if (i_a[3:0] > mie_pkg::BCD_MAX || i_ac) begin
			adj = adj | mie_pkg::DAA_LO;
		end
		if (i_a[7:4] > mie_pkg::BCD_MAX || i_cin) begin
			adj = adj | mie_pkg::DAA_HI;
		end
		daa_full = {1'b0, i_a} + {1'b0, adj};
		o_daa    = daa_full[7:0];
		o_daa_c  = daa_full[8] | adj[6];
	end
endmodule
`default_nettype wire

// ### tb/mie_far_model.sv
/*
 * Far side of the execute block: one data byte, program memory and a watchdog counter.
 * Assumes the bench steers the data byte by reference between operations.
 */
`timescale 1ns/10ps
`default_nettype none
module mie_far_model #(
	parameter int PC_W = 13
) (
	input  wire logic            i_clk,
	input  wire logic            i_mem_we,
	input  wire logic      [7:0] i_mem_wdata,
	input  wire logic            i_rom_re,
	input  wire logic [PC_W-1:0] i_rom_addr,
	input  wire logic            i_wdt_clear,
	output logic           [7:0] o_mem_rdata,
	output logic          [15:0] o_rom_data,
	output logic          [15:0] o_wdt_count
);
	logic [7:0] mem_q = 8'h00;
	initial o_wdt_count = 16'h0000;
	assign o_mem_rdata = mem_q;
	// word is its own address; an idle bus shows the inverse so stale data never looks valid
	assign o_rom_data = i_rom_re ? 16'(i_rom_addr) : ~16'(i_rom_addr);
	always @(posedge i_clk) begin
		if (i_mem_we)
			mem_q <= i_mem_wdata;
		o_wdt_count <= i_wdt_clear ? 16'h0000 : o_wdt_count + 16'h0001;
	end
endmodule
`default_nettype wire

// ### tb/test_mcu_instruction_execute_subset.sv
/*
 * Self-checking bench for the execute block, one task per scenario.
 * Assumes the far model stands in for data memory, program memory and watchdog.
 */
`timescale 1ns/10ps
`default_nettype none
module test_mcu_instruction_execute_subset;
	logic i_clk = 0, i_rst_n = 0, i_op_valid = 0, i_pcl_dest = 0, i_wake = 0, i_ce = 1;
	mie_pkg::mie_op_t i_op = mie_pkg::OP_NOP;
	logic [7:0] i_imm = 8'h00, i_tbl_page = 8'h00;
	logic [2:0] i_bit = 3'h0;
	logic [12:0] i_pc = 13'h0000, i_target = 13'h0000, rom_a, push_a, pc_t, o_rom_addr;
	logic [12:0] o_push_addr, o_pc_target;
	logic [15:0] i_rom_data, wdt;
	logic [7:0] i_mem_rdata, o_mem_wdata, o_acc, o_table_pointer_reg, o_table_high_byte_reg;
	logic [4:0] o_flags;
	logic o_ready, o_skip, o_mem_we, o_rom_re, o_push, o_pc_load, o_wdt_clear, o_clk_gate;
	logic o_timeout_flag, o_power_down_flag;
	int err_count = 0, n_checks = 0;
	always #5 i_clk = ~i_clk;
	mie_core #(.PC_W(13)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
		.i_op_valid(i_op_valid), .i_op(i_op), .i_imm(i_imm), .i_bit(i_bit),
		.i_pcl_dest(i_pcl_dest), .i_pc(i_pc), .i_target(i_target), .i_mem_rdata(i_mem_rdata),
		.i_rom_data(i_rom_data), .i_tbl_page(i_tbl_page), .i_wake(i_wake), .o_ready(o_ready),
		.o_skip(o_skip), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata),
		.o_rom_addr(o_rom_addr), .o_rom_re(o_rom_re), .o_push(o_push),
		.o_push_addr(o_push_addr), .o_pc_load(o_pc_load), .o_pc_target(o_pc_target),
		.o_wdt_clear(o_wdt_clear), .o_clk_gate(o_clk_gate), .o_acc(o_acc), .o_flags(o_flags),
		.o_table_pointer_reg(o_table_pointer_reg), .o_table_high_byte_reg(o_table_high_byte_reg), .o_timeout_flag(o_timeout_flag),
		.o_power_down_flag(o_power_down_flag));
	mie_far_model #(.PC_W(13)) FAR (.i_clk(i_clk), .i_mem_we(o_mem_we),
		.i_mem_wdata(o_mem_wdata), .i_rom_re(o_rom_re), .i_rom_addr(o_rom_addr),
		.i_wdt_clear(o_wdt_clear), .o_mem_rdata(i_mem_rdata), .o_rom_data(i_rom_data),
		.o_wdt_count(wdt));
	always @(posedge i_clk) begin
		if (o_rom_re)
			rom_a <= o_rom_addr;
		if (o_push)
			push_a <= o_push_addr;
		if (o_pc_load)
			pc_t <= o_pc_target;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one operation: offered, accepted, run to ready, then state compared
	task automatic ex(input mie_pkg::mie_op_t op, input logic [7:0] imm, mem, eacc,
		input logic [4:0] efl, input logic [7:0] emem, input int ecyc, input logic esk);
		int cyc;
		logic sk;
		@(posedge i_clk);
		#1;
		i_op = op;
		i_imm = imm;
		i_op_valid = 1;
		FAR.mem_q = mem;
		@(posedge i_clk);
		#1;
		i_op_valid = 0;
		cyc = 1;
		sk = o_skip;
		while (o_ready !== 1'b1 && cyc < 20) begin
			@(posedge i_clk);
			#1;
			cyc++;
		end
		chk(16'(cyc), 16'(ecyc));
		chk(16'(sk), 16'(esk));
		chk(16'(o_acc), 16'(eacc));
		chk(16'(o_flags), 16'(efl));
		chk(16'(FAR.mem_q), 16'(emem));
	endtask
	task automatic t_arith;
		ex(mie_pkg::OP_ADD_IMM, 8'h7F, 8'h00, 8'h7F, 5'h00, 8'h00, 2, 1'b0);
		ex(mie_pkg::OP_ADD_IMM, 8'h01, 8'h00, 8'h80, 5'h0A, 8'h00, 2, 1'b0);
		ex(mie_pkg::OP_ADD_WITH_CARRY, 8'h00, 8'h80, 8'h00, 5'h1D, 8'h80, 2, 1'b0);
		ex(mie_pkg::OP_ADD_WITH_CARRY_TO_MEM, 8'h00, 8'h05, 8'h00, 5'h00, 8'h06, 2, 1'b0);
		ex(mie_pkg::OP_AND_IMM, 8'hFF, 8'h00, 8'h00, 5'h04, 8'h00, 2, 1'b0);
		i_pcl_dest = 1;
		ex(mie_pkg::OP_ADD, 8'h00, 8'hAB, 8'hAB, 5'h00, 8'hAB, 3, 1'b0);
		i_pcl_dest = 0;
		ex(mie_pkg::OP_DECIMAL_ADJUST, 8'h00, 8'h00, 8'hAB, 5'h01, 8'h11, 2, 1'b0);
		ex(mie_pkg::OP_DECREMENT_TO_ACC, 8'h00, 8'h01, 8'h00, 5'h05, 8'h01, 2, 1'b0);
		ex(mie_pkg::OP_COMPLEMENT_BYTE, 8'h00, 8'h0F, 8'h00, 5'h01, 8'hF0, 2, 1'b0);
		ex(mie_pkg::OP_COMPLEMENT_TO_ACC, 8'h00, 8'h0F, 8'hF0, 5'h01, 8'h0F, 2, 1'b0);
		ex(mie_pkg::OP_DECREMENT_BYTE, 8'h00, 8'h01, 8'hF0, 5'h05, 8'h00, 2, 1'b0);
		ex(mie_pkg::OP_AND_TO_MEM, 8'h00, 8'h3C, 8'hF0, 5'h01, 8'h30, 2, 1'b0);
		ex(mie_pkg::OP_ADD_TO_MEM, 8'h00, 8'h20, 8'hF0, 5'h11, 8'h10, 2, 1'b0);
		ex(mie_pkg::OP_AND, 8'h00, 8'hFF, 8'hF0, 5'h11, 8'hFF, 2, 1'b0);
		$display("test arith done");
	endtask
	task automatic t_skip;
		i_bit = 3'h2;
		ex(mie_pkg::OP_EXT_SKIP_IF_ZERO, 8'h00, 8'h00, 8'hF0, 5'h11, 8'h00, 3, 1'b1);
		ex(mie_pkg::OP_EXT_SKIP_IF_ZERO, 8'h00, 8'h01, 8'hF0, 5'h11, 8'h01, 2, 1'b0);
		ex(mie_pkg::OP_EXT_SKIP_IF_NONZERO, 8'h00, 8'h01, 8'hF0, 5'h11, 8'h01, 3, 1'b1);
		ex(mie_pkg::OP_EXT_SKIP_BIT_ZERO, 8'h00, 8'hFB, 8'hF0, 5'h11, 8'hFB, 3, 1'b1);
		ex(mie_pkg::OP_EXT_SKIP_BIT_NONZERO, 8'h00, 8'hFB, 8'hF0, 5'h11, 8'hFB, 2, 1'b0);
		ex(mie_pkg::OP_EXT_INC_SKIP_ZERO, 8'h00, 8'hFF, 8'hF0, 5'h11, 8'h00, 3, 1'b1);
		ex(mie_pkg::OP_EXT_DEC_SKIP_ZERO, 8'h00, 8'h02, 8'hF0, 5'h11, 8'h01, 2, 1'b0);
		ex(mie_pkg::OP_EXT_INC_SKIP_ZERO_TO_ACC, 8'h00, 8'h7F, 8'h80, 5'h11, 8'h7F, 2, 1'b0);
		ex(mie_pkg::OP_EXT_SKIP_ZERO_MOVE_TO_ACC, 8'h00, 8'h00, 8'h00, 5'h11, 8'h00, 3, 1'b1);
		ex(mie_pkg::OP_EXT_DEC_SKIP_ZERO_TO_ACC, 8'h00, 8'h01, 8'h00, 5'h11, 8'h01, 3, 1'b1);
		$display("test skip done");
	endtask
	task automatic t_misc;
		i_bit = 3'h3;
		ex(mie_pkg::OP_EXT_CLEAR_BYTE, 8'h00, 8'h5A, 8'h00, 5'h11, 8'h00, 2, 1'b0);
		ex(mie_pkg::OP_EXT_SET_BYTE, 8'h00, 8'h5A, 8'h00, 5'h11, 8'hFF, 2, 1'b0);
		ex(mie_pkg::OP_EXT_NIBBLE_SWAP, 8'h00, 8'h12, 8'h00, 5'h11, 8'h21, 2, 1'b0);
		ex(mie_pkg::OP_EXT_NIBBLE_SWAP_TO_ACC, 8'h00, 8'h12, 8'h21, 5'h11, 8'h12, 2, 1'b0);
		ex(mie_pkg::OP_CLEAR_BYTE, 8'h00, 8'h5A, 8'h21, 5'h11, 8'h00, 2, 1'b0);
		ex(mie_pkg::OP_CLEAR_BIT, 8'h00, 8'hFF, 8'h21, 5'h11, 8'hF7, 2, 1'b0);
		ex(mie_pkg::OP_NOP, 8'h00, 8'h5A, 8'h21, 5'h11, 8'h5A, 2, 1'b0);
		i_pc = 13'h0123;
		i_target = 13'h0456;
		ex(mie_pkg::OP_CALL, 8'h00, 8'h5A, 8'h21, 5'h11, 8'h5A, 2, 1'b0);
		chk(16'(push_a), 16'h0124);
		chk(16'(pc_t), 16'h0456);
		$display("test misc done");
	endtask
	task automatic t_table;
		ex(mie_pkg::OP_EXT_PREINC_TABLE_READ_LAST, 8'h00, 8'h00, 8'h21, 5'h11, 8'h01, 3, 1'b0);
		chk(16'(rom_a), 16'h1F01);
		chk(16'(o_table_high_byte_reg), 16'h001F);
		i_tbl_page = 8'h05;
		ex(mie_pkg::OP_EXT_TABLE_READ_PAGE, 8'h00, 8'h00, 8'h21, 5'h11, 8'h01, 3, 1'b0);
		chk(16'(rom_a), 16'h0501);
		ex(mie_pkg::OP_EXT_PREINC_TABLE_READ_PAGE, 8'h00, 8'h00, 8'h21, 5'h11, 8'h02, 3, 1'b0);
		chk(16'(o_table_high_byte_reg), 16'h0005);
		ex(mie_pkg::OP_EXT_TABLE_READ_LAST_PAGE, 8'h00, 8'h00, 8'h21, 5'h11, 8'h02, 3, 1'b0);
		chk(16'(rom_a), 16'h1F02);
		chk(16'(o_table_pointer_reg), 16'h0002);
		$display("test table done");
	endtask
	// clock enable low: an offered op is neither taken nor executed until it rises
	task automatic t_freeze;
		@(posedge i_clk);
		#1;
		i_ce = 0;
		i_op = mie_pkg::OP_EXT_SET_BYTE;
		i_op_valid = 1;
		FAR.mem_q = 8'h00;
		repeat (3) @(posedge i_clk);
		#1;
		chk(16'({o_ready, o_mem_we, FAR.mem_q}), 16'h0200);
		i_ce = 1;
		@(posedge i_clk);
		#1;
		i_op_valid = 0;
		repeat (2) @(posedge i_clk);
		#1;
		chk(16'({o_ready, FAR.mem_q}), 16'h01FF);
		$display("test freeze done");
	endtask
	task automatic t_halt;
		int n;
		@(posedge i_clk);
		#1;
		i_op = mie_pkg::OP_HALT;
		i_op_valid = 1;
		@(posedge i_clk);
		#1;
		i_op_valid = 0;
		repeat (3) @(posedge i_clk);
		#1;
		chk(16'(o_clk_gate), 16'h0001);
		chk(16'(o_ready), 16'h0000);
		chk(16'(o_acc), 16'h0021);
		chk(16'(wdt < 16'h0004), 16'h0001);
		chk(16'({o_power_down_flag, o_timeout_flag}), 16'h0002);
		i_wake = 1;
		n = 0;
		while (o_ready !== 1'b1 && n < 20) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		i_wake = 0;
		ex(mie_pkg::OP_CLEAR_WATCHDOG, 8'h00, 8'h5A, 8'h21, 5'h11, 8'h5A, 2, 1'b0);
		chk(16'({o_power_down_flag, o_timeout_flag}), 16'h0000);
		chk(16'(wdt < 16'h0004), 16'h0001);
		$display("test halt done");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge i_clk);
		#1;
		i_rst_n = 1;
		chk(16'({o_ready, o_acc}), 16'h0100);
		t_arith();
		t_skip();
		t_misc();
		t_table();
		t_halt();
		t_freeze();
		conclude();
	end
	initial begin
		#200000;
		err_count++;
		conclude();
	end
endmodule
`default_nettype wire
